/* verilog/axis_pkg.sv */
/*
  Shared constants for the axis torque-stop and ramp-change logic:
  register offsets, field positions, reset values, error codes, modes.
  Assumes a byte-addressed register port with 32-bit data words.
*/
package axis_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_SOFT_UP   = 8'h04;
  localparam logic [7:0] REG_SOFT_LO   = 8'h08;
  localparam logic [7:0] REG_NEW_ACC   = 8'h0C;
  localparam logic [7:0] REG_NEW_DEC   = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_ERR       = 8'h18;
  localparam logic [7:0] REG_FEED      = 8'h1C;
  localparam logic [7:0] REG_REAL      = 8'h20;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h24;
  localparam logic [7:0] REG_IRQ_CLR   = 8'h28;
  localparam logic [7:0] REG_IRQ_EN    = 8'h2C;
  localparam logic [7:0] REG_RAMP      = 8'h30;

  // Control register fields
  localparam int CTRL_RAMP_EN  = 0;
  localparam int CTRL_SOFT_EN  = 1;
  localparam int CTRL_TORQUE   = 2;

  // Interrupt event bits
  localparam int IRQ_MINOR     = 0;
  localparam int IRQ_MAJOR     = 1;
  localparam int IRQ_POS_BACK  = 2;
  localparam int IRQ_RAMP_CHG  = 3;
  localparam int IRQ_W         = 4;

  // Zero-speed bit of the amplifier status word
  localparam int AMP_ZERO_SPEED_BIT = 3;

  // Error codes
  localparam logic [15:0] ERR_MINOR_READY = 16'h00C8; // 200
  localparam logic [15:0] ERR_MINOR_SOFT  = 16'h00CF; // 207
  localparam logic [15:0] ERR_MAJOR_SOFT  = 16'h044D; // 1101
  localparam logic [15:0] ERR_MAJOR_HARD  = 16'h044E; // 1102

  // Reset values
  localparam logic [31:0] SOFT_UP_RST = 32'h7FFFFFFF;
  localparam logic [31:0] SOFT_LO_RST = 32'h80000000;
  localparam logic [15:0] TIME_RST    = 16'h0000;

  typedef enum logic [4:0] {
    MODE_POS      = 5'b00001,
    MODE_TORQUE   = 5'b00010,
    MODE_STOPPING = 5'b00100,
    MODE_SRV_WAIT = 5'b01000,
    MODE_FREE_RUN = 5'b10000
  } axis_mode_t;

endpackage

/* verilog/ramp_if.sv */
/*
  Carrier between the axis top and the ramp-time selector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface ramp_if;
  logic        change_en;
  logic [15:0] new_acc;
  logic [15:0] new_dec;
  logic [3:0]  req;
  logic [15:0] acc_time;
  logic [15:0] dec_time;
  logic        changed;

  modport ctrl (output change_en, output new_acc, output new_dec, output req,
                input acc_time, input dec_time, input changed);
  modport sel  (input change_en, input new_acc, input new_dec, input req,
                output acc_time, output dec_time, output changed);
endinterface

/* verilog/ramp_time_sel.sv */
/*
  Ramp-time selector: holds the acceleration and deceleration times of the
  positioning in progress and swaps them on an accepted speed-change request.
  Assumes start and point_advance are one-cycle pulses from the motion core.
*/
`timescale 1ns/1ns
module ramp_time_sel (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Motion core
  input  wire logic        start,
  input  wire logic        point_advance,
  input  wire logic [15:0] start_acc,
  input  wire logic [15:0] start_dec,
  input  wire logic        virtual_axis,
  // Link to the axis top
  ramp_if.sel              rp
);

  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] dec;
    logic [15:0] base_acc;
    logic [15:0] base_dec;
    logic        changed;
  } ramp_state_t;

  ramp_state_t st;
  ramp_state_t next_st;

  always_comb begin
    next_st         = st;
    next_st.changed = 1'b0;
    if (start) begin
      next_st.base_acc = start_acc;
      next_st.base_dec = start_dec;
      next_st.acc      = start_acc;
      next_st.dec      = start_dec;
    end else if (point_advance) begin
      // Changed times last only until the next positioning point
      next_st.acc = st.base_acc;
      next_st.dec = st.base_dec;
    end else if (|rp.req && rp.change_en && !virtual_axis) begin
      // Zero keeps the present time
      if (rp.new_acc != 16'h0000) begin
        next_st.acc = rp.new_acc;
      end
      if (rp.new_dec != 16'h0000) begin
        next_st.dec = rp.new_dec;
      end
      next_st.changed = (rp.new_acc != 16'h0000) || (rp.new_dec != 16'h0000);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '{acc: axis_pkg::TIME_RST, dec: axis_pkg::TIME_RST, base_acc: axis_pkg::TIME_RST,
              base_dec: axis_pkg::TIME_RST, changed: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rp.acc_time = st.acc;
  assign rp.dec_time = st.dec;
  assign rp.changed  = st.changed;

endmodule

/* verilog/axis_torque_ctrl.sv */
/*
  Per-axis torque-mode stop handling and ramp-time change control, with a
  register port and one level interrupt.
  Assumes all inputs are synchronous to mclk and op_tick marks the operation
  cycle with a one-cycle pulse.
*/
// Operation
// - Feed and real positions keep updating every operation cycle in torque mode.
// - Feed position beyond soft stroke limit: minor error 207, back to position.
// - Stop, rapid-stop or external stop: speed limit output forced to zero.
// - After that stop, zero-speed bit b3 switches to position, immediate halt.
// - Torque output stays unchanged during such a stop.
// - Servo-off requests deferred in torque mode, applied back in position control.
// - Stroke limits or ready loss: errors, position control at present spot.
// - Forced stops or servo error: position control once servo-ready drops.
// - Amplifier power loss: free run, position control when power returns.
// - Speed change uses configured ramp times when enabled, else keeps the present times.
// - Changed ramp times hold only until the next positioning point.
// - Four speed-change requests may carry a ramp-time change.
// - Requests to a virtual axis change speed but not ramp times.
`timescale 1ns/1ns
module axis_torque_ctrl (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Operation cycle and program side
  input  wire logic        op_tick,
  input  wire logic        system_ready_flag,
  input  wire logic        axis_stop_cmd,
  input  wire logic        axis_rapid_stop_cmd,
  input  wire logic        ext_stop_in,
  input  wire logic        all_axes_servo_on_cmd,
  input  wire logic        axis_servo_off_cmd,
  input  wire logic        forced_stop_ctrl,
  input  wire logic        hw_stroke_limit,
  input  wire logic signed [31:0] speed_cmd,
  input  wire logic signed [15:0] torque_cmd,
  input  wire logic signed [31:0] feed_delta,
  input  wire logic signed [31:0] real_delta,
  // Speed-change requests and positioning progress
  input  wire logic        speed_change_req,
  input  wire logic        gen_axis_speed_change_req,
  input  wire logic        ladder_speed_change_req,
  input  wire logic        ladder_gen_axis_speed_change_req,
  input  wire logic        virtual_axis,
  input  wire logic        pos_start,
  input  wire logic        point_advance,
  input  wire logic [15:0] start_acc_time,
  input  wire logic [15:0] start_dec_time,
  // Servo amplifier
  input  wire logic        forced_stop_amp,
  input  wire logic        servo_error,
  input  wire logic        amp_servo_ready,
  input  wire logic        amp_power_on,
  input  wire logic [15:0] amp_status_word2,
  output logic signed [31:0] speed_limit_out,
  output logic signed [15:0] torque_out,
  output logic             servo_on_out,
  output logic             immediate_stop,
  output logic             free_run,
  // Motion state
  output logic signed [31:0] feed_position_value,
  output logic signed [31:0] real_position_value,
  output logic [4:0]       axis_mode,
  output logic [15:0]      acc_time,
  output logic [15:0]      dec_time,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq
);

  typedef struct packed {
    axis_pkg::axis_mode_t      mode;
    logic signed [31:0]        feed;
    logic signed [31:0]        real_pos;
    logic signed [31:0]        speed_lim;
    logic signed [15:0]        torque;
    logic                      servo_on;
    logic                      stop_pulse;
    logic [15:0]               minor_err;
    logic [15:0]               major_err;
    logic [2:0]                ctrl;
    logic [31:0]               soft_up;
    logic [31:0]               soft_lo;
    logic [15:0]               new_acc;
    logic [15:0]               new_dec;
    logic [axis_pkg::IRQ_W-1:0] irq_stat;
    logic [axis_pkg::IRQ_W-1:0] irq_en;
    logic [31:0]               rdata;
  } axis_state_t;

  axis_state_t st;
  axis_state_t next_st;
  ramp_if      rp ();

  ramp_time_sel u_ramp (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .start         (pos_start),
    .point_advance (point_advance),
    .start_acc     (start_acc_time),
    .start_dec     (start_dec_time),
    .virtual_axis  (virtual_axis),
    .rp            (rp)
  );

  assign rp.change_en = st.ctrl[axis_pkg::CTRL_RAMP_EN];
  assign rp.new_acc   = st.new_acc;
  assign rp.new_dec   = st.new_dec;
  assign rp.req       = {ladder_gen_axis_speed_change_req, ladder_speed_change_req,
                         gen_axis_speed_change_req, speed_change_req};

  logic                      in_torque;
  logic                      soft_hit;
  logic                      stop_in;
  logic                      forced_in;
  logic                      servo_cmd;
  logic signed [31:0]        feed_next;
  logic [axis_pkg::IRQ_W-1:0] ev;
  logic [axis_pkg::IRQ_W-1:0] clr;

  always_comb begin
    next_st            = st;
    next_st.stop_pulse = 1'b0;
    ev                 = '0;
    clr                = '0;
    in_torque = (st.mode == axis_pkg::MODE_TORQUE) || (st.mode == axis_pkg::MODE_STOPPING)
                || (st.mode == axis_pkg::MODE_SRV_WAIT);
    feed_next = st.feed + feed_delta;
    soft_hit  = st.ctrl[axis_pkg::CTRL_SOFT_EN]
                && ((feed_next > $signed(st.soft_up)) || (feed_next < $signed(st.soft_lo)));
    stop_in   = axis_stop_cmd || axis_rapid_stop_cmd || ext_stop_in;
    forced_in = forced_stop_ctrl || forced_stop_amp || servo_error;
    servo_cmd = all_axes_servo_on_cmd && !axis_servo_off_cmd;

    if (op_tick) begin
      // Positions run on in every mode so a return to position control is seamless
      next_st.feed     = feed_next;
      next_st.real_pos = st.real_pos + real_delta;
    end

    if (op_tick) begin
      // Immediate causes first, then power loss, forced stops, then stop inputs
      if (in_torque && (soft_hit || hw_stroke_limit || !system_ready_flag)) begin
        // Present position, no ramp down
        next_st.mode       = axis_pkg::MODE_POS;
        next_st.stop_pulse = 1'b1;
        next_st.speed_lim  = '0;
        if (soft_hit) begin
          next_st.minor_err       = axis_pkg::ERR_MINOR_SOFT;
          next_st.major_err       = axis_pkg::ERR_MAJOR_SOFT;
          ev[axis_pkg::IRQ_MINOR] = 1'b1;
          ev[axis_pkg::IRQ_MAJOR] = 1'b1;
        end else if (hw_stroke_limit) begin
          next_st.major_err       = axis_pkg::ERR_MAJOR_HARD;
          ev[axis_pkg::IRQ_MAJOR] = 1'b1;
        end else begin
          next_st.minor_err       = axis_pkg::ERR_MINOR_READY;
          ev[axis_pkg::IRQ_MINOR] = 1'b1;
        end
        ev[axis_pkg::IRQ_POS_BACK] = 1'b1;
      end else begin
        unique case (st.mode)
          axis_pkg::MODE_POS: begin
            // Deferred servo-off applies here
            next_st.servo_on  = servo_cmd;
            next_st.speed_lim = '0;
            next_st.torque    = '0;
            if (st.ctrl[axis_pkg::CTRL_TORQUE] && servo_cmd && amp_power_on && system_ready_flag) begin
              next_st.mode     = axis_pkg::MODE_TORQUE;
              next_st.servo_on = 1'b1;
            end
          end
          axis_pkg::MODE_TORQUE: begin
            next_st.speed_lim = speed_cmd;
            next_st.torque    = torque_cmd;
            if (!amp_power_on) begin
              next_st.mode = axis_pkg::MODE_FREE_RUN;
            end else if (forced_in) begin
              next_st.mode = axis_pkg::MODE_SRV_WAIT;
            end else if (stop_in) begin
              next_st.mode      = axis_pkg::MODE_STOPPING;
              next_st.speed_lim = '0;
              next_st.torque    = st.torque;
            end else if (!st.ctrl[axis_pkg::CTRL_TORQUE]) begin
              next_st.mode = axis_pkg::MODE_POS;
            end
          end
          axis_pkg::MODE_STOPPING: begin
            // Torque stays where it was; reaching zero speed may take a while
            next_st.speed_lim = '0;
            if (!amp_power_on) begin
              next_st.mode = axis_pkg::MODE_FREE_RUN;
            end else if (forced_in) begin
              next_st.mode = axis_pkg::MODE_SRV_WAIT;
            end else if (amp_status_word2[axis_pkg::AMP_ZERO_SPEED_BIT]) begin
              next_st.mode               = axis_pkg::MODE_POS;
              next_st.stop_pulse         = 1'b1;
              ev[axis_pkg::IRQ_POS_BACK] = 1'b1;
            end
          end
          axis_pkg::MODE_SRV_WAIT: begin
            // Wait for the amplifier to cut the servo
            if (!amp_power_on) begin
              next_st.mode = axis_pkg::MODE_FREE_RUN;
            end else if (!amp_servo_ready) begin
              next_st.mode               = axis_pkg::MODE_POS;
              next_st.speed_lim          = '0;
              ev[axis_pkg::IRQ_POS_BACK] = 1'b1;
            end
          end
          axis_pkg::MODE_FREE_RUN: begin
            // Motor coasts until power returns
            next_st.speed_lim = '0;
            next_st.torque    = '0;
            if (amp_power_on) begin
              next_st.mode               = axis_pkg::MODE_POS;
              ev[axis_pkg::IRQ_POS_BACK] = 1'b1;
            end
          end
          default: begin
            next_st.mode = axis_pkg::MODE_POS;
          end
        endcase
      end
    end

    ev[axis_pkg::IRQ_RAMP_CHG] = rp.changed;

    next_st.rdata = '0;
    // Read-only and unmapped offsets ignore writes
    if (reg_wr) begin
      unique case (reg_addr)
        axis_pkg::REG_CTRL:     next_st.ctrl    = reg_wdata[2:0];
        axis_pkg::REG_SOFT_UP:  next_st.soft_up = reg_wdata;
        axis_pkg::REG_SOFT_LO:  next_st.soft_lo = reg_wdata;
        axis_pkg::REG_NEW_ACC:  next_st.new_acc = reg_wdata[15:0];
        axis_pkg::REG_NEW_DEC:  next_st.new_dec = reg_wdata[15:0];
        axis_pkg::REG_IRQ_CLR:  clr             = reg_wdata[axis_pkg::IRQ_W-1:0];
        axis_pkg::REG_IRQ_EN:   next_st.irq_en  = reg_wdata[axis_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      unique case (reg_addr)
        axis_pkg::REG_CTRL:     next_st.rdata = {29'h0, st.ctrl};
        axis_pkg::REG_SOFT_UP:  next_st.rdata = st.soft_up;
        axis_pkg::REG_SOFT_LO:  next_st.rdata = st.soft_lo;
        axis_pkg::REG_NEW_ACC:  next_st.rdata = {16'h0, st.new_acc};
        axis_pkg::REG_NEW_DEC:  next_st.rdata = {16'h0, st.new_dec};
        axis_pkg::REG_STATUS:   next_st.rdata = {25'h0, free_run, st.servo_on, st.mode};
        axis_pkg::REG_ERR:      next_st.rdata = {st.major_err, st.minor_err};
        axis_pkg::REG_FEED:     next_st.rdata = st.feed;
        axis_pkg::REG_REAL:     next_st.rdata = st.real_pos;
        axis_pkg::REG_IRQ_STAT: next_st.rdata = {28'h0, st.irq_stat};
        axis_pkg::REG_IRQ_EN:   next_st.rdata = {28'h0, st.irq_en};
        axis_pkg::REG_RAMP:     next_st.rdata = {rp.dec_time, rp.acc_time};
        default:                next_st.rdata = '0;
      endcase
    end

    // A new event outranks a clear in the same cycle
    next_st.irq_stat = (st.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st <= '{mode: axis_pkg::MODE_POS, feed: '0, real_pos: '0, speed_lim: '0, torque: '0,
              servo_on: 1'b0, stop_pulse: 1'b0, minor_err: '0, major_err: '0, ctrl: '0,
              soft_up: axis_pkg::SOFT_UP_RST, soft_lo: axis_pkg::SOFT_LO_RST,
              new_acc: axis_pkg::TIME_RST, new_dec: axis_pkg::TIME_RST,
              irq_stat: '0, irq_en: '0, rdata: '0};
    end else begin
      st <= next_st;
    end
  end

  assign speed_limit_out     = st.speed_lim;
  assign torque_out          = st.torque;
  assign servo_on_out        = st.servo_on;
  assign immediate_stop      = st.stop_pulse;
  assign free_run            = (st.mode == axis_pkg::MODE_FREE_RUN);
  assign feed_position_value = st.feed;
  assign real_position_value = st.real_pos;
  assign axis_mode           = st.mode;
  assign acc_time            = rp.acc_time;
  assign dec_time            = rp.dec_time;
  assign reg_rdata           = st.rdata;

  // Any enabled sticky bit holds the line high
  assign irq                 = |(st.irq_stat & st.irq_en);

endmodule

/* verif/axis_torque_ctrl_chk.sv */
/*
  Concurrent checks on the axis torque-stop and ramp-change block.
  Assumes a single mclk domain and the synchronous sys_rst of the top.
*/
`timescale 1ns/1ns
module axis_torque_ctrl_chk (
  // Clock, reset, operation cycle
  input wire logic               mclk, sys_rst, op_tick,
  // Causes
  input wire logic               system_ready_flag, hw_stroke_limit, amp_power_on, amp_servo_ready,
  input wire logic               forced_stop_ctrl, forced_stop_amp, servo_error,
  input wire logic               all_axes_servo_on_cmd, axis_servo_off_cmd,
  input wire logic [15:0]        amp_status_word2,
  input wire logic signed [31:0] feed_delta, real_delta,
  // Ramp side
  input wire logic               speed_change_req, gen_axis_speed_change_req, ladder_speed_change_req,
  input wire logic               ladder_gen_axis_speed_change_req, virtual_axis, pos_start, point_advance,
  input wire logic [15:0]        start_acc_time, start_dec_time, acc_time, dec_time,
  // Outputs
  input wire logic signed [31:0] speed_limit_out, feed_position_value, real_position_value,
  input wire logic signed [15:0] torque_out,
  input wire logic               servo_on_out, immediate_stop,
  input wire logic [4:0]         axis_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic tq_m, calm, flt, rq;
  assign tq_m = axis_mode inside {axis_pkg::MODE_TORQUE, axis_pkg::MODE_STOPPING, axis_pkg::MODE_SRV_WAIT};
  assign calm = system_ready_flag && !hw_stroke_limit && amp_power_on;
  assign flt  = forced_stop_ctrl || forced_stop_amp || servo_error;
  assign rq   = speed_change_req || gen_axis_speed_change_req || ladder_speed_change_req
                || ladder_gen_axis_speed_change_req;
  sequence back_pos;
    axis_mode == axis_pkg::MODE_POS && immediate_stop;
  endsequence
  sequence zero_tick;
    op_tick && axis_mode == axis_pkg::MODE_STOPPING && amp_status_word2[3] && calm && !flt;
  endsequence
  pos_track_a: assert property (op_tick |=> feed_position_value == $past(feed_position_value) + $past(feed_delta)
    && real_position_value == $past(real_position_value) + $past(real_delta)) else $error("position not updated");
  stop_zero_a: assert property (axis_mode == axis_pkg::MODE_STOPPING |-> speed_limit_out == 0)
    else $error("speed limit not zero while stopping");
  zero_exit_a: assert property (zero_tick |=> back_pos) else $error("zero speed did not end stop");
  torque_hold_a: assert property (axis_mode == axis_pkg::MODE_STOPPING ##1 axis_mode == axis_pkg::MODE_STOPPING
    |-> $stable(torque_out)) else $error("torque changed while stopping");
  servo_hold_a: assert property (axis_mode != axis_pkg::MODE_POS |-> servo_on_out)
    else $error("servo dropped outside position control");
  servo_apply_a: assert property (op_tick && axis_mode == axis_pkg::MODE_POS |=>
    servo_on_out == $past(all_axes_servo_on_cmd && !axis_servo_off_cmd)) else $error("servo command not applied");
  limit_exit_a: assert property (op_tick && tq_m && (!system_ready_flag || hw_stroke_limit) |=> back_pos)
    else $error("limit or ready loss did not stop");
  srv_exit_a: assert property (op_tick && axis_mode == axis_pkg::MODE_SRV_WAIT && !amp_servo_ready && calm
    |=> axis_mode == axis_pkg::MODE_POS) else $error("servo wait not left");
  free_exit_a: assert property (op_tick && axis_mode == axis_pkg::MODE_FREE_RUN && amp_power_on
    |=> axis_mode == axis_pkg::MODE_POS) else $error("free run not left");
  ramp_start_a: assert property (pos_start |=> acc_time == $past(start_acc_time)
    && dec_time == $past(start_dec_time)) else $error("start ramp times not loaded");
  virt_keep_a: assert property (rq && virtual_axis && !pos_start && !point_advance |=> $stable(acc_time)
    && $stable(dec_time)) else $error("virtual axis ramp changed");
endmodule

bind axis_torque_ctrl axis_torque_ctrl_chk chk_i (.*);

/* verif/amp_model.sv */
/*
  Servo amplifier stand-in: power follows a bench request, servo-ready
  drops a few cycles after a fault, zero speed shows after a quiet spell.
  Assumes the same mclk and sys_rst as the block under test.
*/
`timescale 1ns/1ns
module amp_model (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               sys_rst,
  // Bench and block side
  input wire logic               power_req,
  input wire logic               fault,
  input wire logic signed [31:0] speed_limit_out,
  // Amplifier outputs
  output logic                   amp_power_on,
  output logic                   amp_servo_ready,
  output logic [15:0]            amp_status_word2
);
  logic [7:0] zc;
  logic [2:0] fd;
  // Motor coasts down slowly, so zero speed is reported well after the limit drops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      zc <= 8'h00;
      fd <= 3'h0;
    end else begin
      zc <= (speed_limit_out != 0) ? 8'h00 : ((zc == 8'hFF) ? zc : zc + 8'h01);
      fd <= {fd[1:0], fault};
    end
  end
  assign amp_power_on     = power_req;
  assign amp_servo_ready  = power_req && !fd[2];
  assign amp_status_word2 = {12'h000, zc >= 8'h28, 3'h0};
endmodule

/* verif/test_axis_torque_ctrl.sv */
/*
  Testbench for the axis torque-stop and ramp-change block with an
  amplifier model. Assumes the checker is bound to the top by its own file.
*/
`timescale 1ns/1ns
module test_axis_torque_ctrl;
  logic mclk = 0, sys_rst = 1, op_tick = 0, system_ready_flag = 1, all_axes_servo_on_cmd = 1;
  logic axis_servo_off_cmd = 0, hw_stroke_limit = 0, virtual_axis = 0, pos_start = 0, point_advance = 0, pwr = 1;
  logic reg_wr = 0, reg_rd = 0;
  logic [2:0] stp = 0, flt = 0;
  logic [3:0] sreq = 0;
  // Speed and torque share one direction
  logic signed [31:0] speed_cmd = 32'h3E8, feed_delta = 32'h5, real_delta = 32'h3;
  logic signed [15:0] torque_cmd = 16'h0100, t0;
  logic [15:0] start_acc_time = 16'h01F4, start_dec_time = 16'h0258, amp_status_word2, acc_time, dec_time;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, v;
  logic signed [31:0] speed_limit_out, feed_position_value, real_position_value;
  logic signed [15:0] torque_out;
  logic servo_on_out, immediate_stop, free_run, irq, amp_servo_ready, amp_power_on;
  logic [4:0] axis_mode;
  wire logic axis_stop_cmd, axis_rapid_stop_cmd, ext_stop_in, forced_stop_ctrl, forced_stop_amp, servo_error;
  wire logic speed_change_req, gen_axis_speed_change_req, ladder_speed_change_req, ladder_gen_axis_speed_change_req;
  int mismatches = 0, cmp_count = 0, tc = 0;
  assign {ext_stop_in, axis_rapid_stop_cmd, axis_stop_cmd} = stp;
  assign {servo_error, forced_stop_amp, forced_stop_ctrl} = flt;
  assign {ladder_gen_axis_speed_change_req, ladder_speed_change_req, gen_axis_speed_change_req,
          speed_change_req} = sreq;
  axis_torque_ctrl uut (.*);
  amp_model amp (.power_req(pwr), .fault(|flt), .*);
  always #2 mclk = ~mclk;
  // Long operation cycle leaves room to drop torque mode before re-entry
  always @(posedge mclk) begin
    tc <= (tc == 15) ? 0 : tc + 1;
    op_tick <= (tc == 15);
  end
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task wmode(input logic [4:0] m);
    for (int i = 0; i < 800 && axis_mode !== m; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("mode", {27'h0, m}, {27'h0, axis_mode});
  endtask
  task tq_on(input logic [31:0] c);
    wr(8'h00, c);
    wmode(axis_pkg::MODE_TORQUE);
    // Let a nonzero speed limit reach the amplifier first
    @(posedge mclk iff op_tick);
  endtask
  task req(input int i);
    @(posedge mclk);
    sreq <= 4'h1 << i;
    @(posedge mclk);
    sreq <= 4'h0;
    #1;
  endtask
  // Whole run needs under 10000 cycles
  initial begin
    cyc(30000);
    mismatches++;
    summarize;
  end
  initial begin
    cyc(8);
    sys_rst <= 1'b0;
    rd(8'h14); chk("status", 32'h01, v);
    rd(8'h04); chk("soft_up", 32'h7FFFFFFF, v);
    rd(8'h08); chk("soft_lo", 32'h80000000, v);
    wr(8'h3C, 32'hF); rd(8'h3C); chk("unmapped", 32'h0, v);
    rd(8'h2C); chk("irq_en", 32'h0, v);
    $display("reset test done");
    wr(8'h2C, 32'hF);
    for (int k = 0; k < 3; k++) begin
      tq_on(32'h4); rd(8'h14); chk("status", 32'h22, v);
      stp <= 3'h1 << k;
      wmode(axis_pkg::MODE_STOPPING); chk("speed_limit", 32'h0, speed_limit_out);
      t0 = torque_out;
      torque_cmd <= torque_cmd + 16'h0100;
      cyc(20); chk("torque", {16'h0, t0}, {16'h0, torque_out});
      wmode(axis_pkg::MODE_POS);
      wr(8'h00, 32'h0);
      stp <= 3'h0;
    end
    chk("irq", 1, irq); rd(8'h24); chk("irq_stat", 32'h4, v);
    wr(8'h28, 32'hF); rd(8'h24); chk("irq_stat", 32'h0, v);
    chk("irq", 0, irq);
    $display("stop test done");
    tq_on(32'h4); axis_servo_off_cmd <= 1'b1;
    cyc(40); chk("servo_on", 1, servo_on_out);
    wr(8'h00, 32'h0); wmode(axis_pkg::MODE_POS);
    cyc(20); chk("servo_on", 0, servo_on_out);
    axis_servo_off_cmd <= 1'b0;
    $display("servo test done");
    wr(8'h2C, 32'h0); tq_on(32'h4); system_ready_flag <= 1'b0;
    wmode(axis_pkg::MODE_POS); chk("irq", 0, irq);
    rd(8'h18); chk("minor", 32'hC8, {16'h0, v[15:0]});
    rd(8'h24); chk("irq_stat", 32'h5, v);
    wr(8'h2C, 32'hF); cyc(1); chk("irq", 1, irq);
    wr(8'h28, 32'hF); wr(8'h00, 32'h0); system_ready_flag <= 1'b1;
    tq_on(32'h4); stp <= 3'h1; hw_stroke_limit <= 1'b1;
    @(posedge mclk iff op_tick);
    cyc(1); chk("mode", 32'h1, {27'h0, axis_mode});
    wr(8'h00, 32'h0); hw_stroke_limit <= 1'b0; stp <= 3'h0;
    rd(8'h18); chk("major", 32'h44E, {16'h0, v[31:16]});
    rd(8'h1C); wr(8'h04, v + 32'h64); tq_on(32'h6);
    wmode(axis_pkg::MODE_POS); wr(8'h00, 32'h0);
    rd(8'h18); chk("err", 32'h044D00CF, v);
    $display("limit test done");
    for (int k = 0; k < 3; k++) begin
      tq_on(32'h4); flt <= 3'h1 << k;
      wmode(axis_pkg::MODE_SRV_WAIT); wmode(axis_pkg::MODE_POS);
      wr(8'h00, 32'h0); flt <= 3'h0;
    end
    tq_on(32'h4); pwr <= 1'b0;
    wmode(axis_pkg::MODE_FREE_RUN); chk("free_run", 1, free_run);
    pwr <= 1'b1; wmode(axis_pkg::MODE_POS); wr(8'h00, 32'h0);
    $display("servo fault test done");
    wr(8'h28, 32'hF); wr(8'h00, 32'h1);
    @(posedge mclk); pos_start <= 1'b1;
    @(posedge mclk); pos_start <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h0C, 32'h64 + i); wr(8'h10, (i == 0) ? 32'h0 : 32'hC8 + i);
      req(i); chk("acc", 32'h64 + i, {16'h0, acc_time});
      chk("dec", (i == 0) ? 32'h258 : 32'hC8 + i, {16'h0, dec_time});
    end
    rd(8'h24); chk("irq_stat", 32'h8, v);
    virtual_axis <= 1'b1; wr(8'h0C, 32'h1234);
    req(0); chk("acc", 32'h67, {16'h0, acc_time});
    virtual_axis <= 1'b0; wr(8'h00, 32'h0);
    req(1); chk("acc", 32'h67, {16'h0, acc_time});
    @(posedge mclk); point_advance <= 1'b1;
    @(posedge mclk); point_advance <= 1'b0;
    rd(8'h30); chk("ramp", 32'h025801F4, v);
    $display("ramp test done");
    summarize;
  end
endmodule
